// *** logic/lmd_decoder.sv ***
// lmd_decoder: local memory address decoder with per-region wait states.
// assumes: processor strobe, address and mode on clk_in; straps and the
// remote bus address come from pins and are held stable while in use.
`timescale 1ns/1ns
`default_nettype none
`include "lmd_cfg.svh"

// Function
// RULE1 - remote masters hit dual-port only at its protected-mode window
// RULE2 - both socket pairs decoded as independent regions
// RULE3 - dual-port region is one contiguous range
// RULE4 - dual-port processor accesses always take two wait states
// RULE5 - each socket pair has its own one-to-three wait states
// RULE6 - dual-port block size selectable; local regions have none
// RULE7 - real mode uses 20-bit addresses, protected mode full 24-bit
// RULE8 - default strapping gives 64K of local memory at the top
// RULE9 - local decode covers at most 256K over both pairs
// RULE10 - boot pair always sits at the highest local addresses
// RULE11 - second pair is top-justified below boot pair or set apart
// RULE12 - two primary straps pick one of four memory maps
// RULE13 - three secondary straps size second pair and its justification
// RULE14 - primary straps also set the expansion-bus range; here only in real mode, protected-mode top fixed at dfffff
// RULE15 - local regions sized and placed in 16K blocks only
// RULE16 - local pairs are read-only; writes there are refused
// RULE17 - real-mode dual-port window starts at 0ec000
// RULE18 - one region select per access with its own wait count
module lmd_decoder #(
  parameter logic [1:0] EXP_WAITS = 2'h1,
  parameter logic [1:0] SYS_WAITS = 2'h1
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        cpu_strobe_in,
  input  wire logic        cpu_write_in,
  input  wire logic [23:0] cpu_addr_in,
  input  wire logic        protected_virtual_mode_in,
  input  wire logic [1:0]  primary_opt_in,
  input  wire logic [2:0]  secondary_opt_in,
  input  wire logic [1:0]  boot_wait_sel_in,
  input  wire logic [1:0]  second_wait_sel_in,
  input  wire logic        dp_block_sel_in,
  input  wire logic        remote_valid_in,
  input  wire logic [23:0] remote_addr_in,
  output logic             boot_sel_out,
  output logic             second_sel_out,
  output logic             dual_port_sel_out,
  output logic             expansion_sel_out,
  output logic             system_bus_sel_out,
  output logic             cpu_ready_out,
  output logic             write_refused_out,
  output logic             remote_dual_port_sel_out
);

  // ========================================================
  // state and strap fields
  lmd_pkg::lmd_state_t r, n;

  logic [1:0]  pri;
  logic [2:0]  sec;
  logic [1:0]  bwt;
  logic [1:0]  swt;
  logic        dpb;
  logic        pvm;

  assign pri = r.cfg_use[`LMD_CF_PRI_LSB +: 2];
  assign sec = r.cfg_use[`LMD_CF_SEC_LSB +: 3];
  assign bwt = r.cfg_use[`LMD_CF_BWT_LSB +: 2];
  assign swt = r.cfg_use[`LMD_CF_SWT_LSB +: 2];
  assign dpb = r.cfg_use[`LMD_CF_DPB_BIT];
  assign pvm = protected_virtual_mode_in;

  // ========================================================
  // primary decode tables
  logic [23:0] boot_lo;
  logic [23:0] top;
  logic [23:0] win_lo;
  logic [23:0] win_hi;
  logic [23:0] exp_hi;
  logic [23:0] dp_lo;
  logic [23:0] dp_span;

  always_comb begin
    top    = pvm ? `LMD_TOP_PV : `LMD_TOP_RM; // RULE7 RULE10
    exp_hi = `LMD_EHI_PV;
    case (pri) // RULE12 RULE14
      2'h0: begin
        boot_lo = pvm ? `LMD_O0_BOOT_PV : `LMD_O0_BOOT_RM;
        win_lo  = pvm ? `LMD_O0_SLO_PV : `LMD_O0_SLO_RM;
        win_hi  = pvm ? `LMD_O0_SHI_PV : `LMD_O0_SHI_RM;
        if (!pvm) begin
          exp_hi = `LMD_O0_EHI_RM;
        end
      end
      2'h1: begin
        boot_lo = pvm ? `LMD_O1_BOOT_PV : `LMD_O1_BOOT_RM; // RULE8
        win_lo  = pvm ? `LMD_O1_SLO_PV : `LMD_O1_SLO_RM;
        win_hi  = pvm ? `LMD_O1_SHI_PV : `LMD_O1_SHI_RM;
        if (!pvm) begin
          exp_hi = `LMD_O1_EHI_RM;
        end
      end
      2'h2: begin
        boot_lo = pvm ? `LMD_O2_BOOT_PV : `LMD_O2_BOOT_RM;
        win_lo  = pvm ? `LMD_O2_SLO_PV : `LMD_O2_SLO_RM;
        win_hi  = pvm ? `LMD_O2_SHI_PV : `LMD_O2_SHI_RM;
        if (!pvm) begin
          exp_hi = `LMD_O2_EHI_RM;
        end
      end
      default: begin
        boot_lo = pvm ? `LMD_O3_BOOT_PV : `LMD_O3_BOOT_RM; // RULE9
        win_lo  = pvm ? `LMD_O3_SLO_PV : `LMD_O3_SLO_RM;
        win_hi  = pvm ? `LMD_O3_SHI_PV : `LMD_O3_SHI_RM;
        if (!pvm) begin
          exp_hi = `LMD_O3_EHI_RM;
        end
      end
    endcase
  end

  // ========================================================
  // secondary decode: second pair size and placement in 16K blocks
  logic [9:0]  win_lo_blk;
  logic [9:0]  win_hi_blk;
  logic [9:0]  win_blks;
  logic [9:0]  sec_blks;
  logic [9:0]  sec_lo_blk;
  logic [9:0]  sec_hi_blk;
  logic [23:0] sec_lo;
  logic [23:0] sec_hi;

  always_comb begin
    win_lo_blk = win_lo[23:`LMD_BLK_LSB]; // RULE15
    win_hi_blk = win_hi[23:`LMD_BLK_LSB];
    win_blks   = win_hi_blk - win_lo_blk + 10'h001;
    sec_blks   = win_blks >> sec[1:0]; // RULE13
    if (sec_blks == 10'h000) begin
      sec_blks = 10'h001;
    end
    if (sec[2]) begin
      // set apart at the bottom of the window
      sec_lo_blk = win_lo_blk; // RULE11
      sec_hi_blk = win_lo_blk + sec_blks - 10'h001;
    end else begin
      // butted against the boot pair
      sec_hi_blk = win_hi_blk; // RULE11
      sec_lo_blk = win_hi_blk - sec_blks + 10'h001;
    end
    sec_lo = {sec_lo_blk, 14'h0000};
    sec_hi = {sec_hi_blk, 14'h3fff};
  end

  // ========================================================
  // dual-port window
  always_comb begin
    dp_lo   = pvm ? `LMD_DP_LO_PV : `LMD_DP_LO_RM; // RULE17
    dp_span = dpb ? `LMD_DP_SPAN_LG : `LMD_DP_SPAN_SM; // RULE6
  end

  // ========================================================
  // window compares
  logic [23:0] cmp_addr [0:4];
  logic [23:0] cmp_lo   [0:4];
  logic [23:0] cmp_hi   [0:4];
  logic [4:0]  hit;
  logic [23:0] cpu_addr;

  // upper four bits ignored in real mode
  assign cpu_addr = pvm ? cpu_addr_in : (cpu_addr_in & `LMD_RM_MASK); // RULE7

  always_comb begin
    cmp_addr[lmd_pkg::LMD_RG_BOOT]   = cpu_addr;
    cmp_lo[lmd_pkg::LMD_RG_BOOT]     = boot_lo; // RULE2
    cmp_hi[lmd_pkg::LMD_RG_BOOT]     = top;
    cmp_addr[lmd_pkg::LMD_RG_SECOND] = cpu_addr;
    cmp_lo[lmd_pkg::LMD_RG_SECOND]   = sec_lo; // RULE2
    cmp_hi[lmd_pkg::LMD_RG_SECOND]   = sec_hi;
    cmp_addr[lmd_pkg::LMD_RG_DP]     = cpu_addr;
    cmp_lo[lmd_pkg::LMD_RG_DP]       = dp_lo; // RULE3
    cmp_hi[lmd_pkg::LMD_RG_DP]       = dp_lo + dp_span - 24'h000001;
    cmp_addr[lmd_pkg::LMD_RG_EXP]    = cpu_addr;
    cmp_lo[lmd_pkg::LMD_RG_EXP]      = `LMD_EXP_LO;
    cmp_hi[lmd_pkg::LMD_RG_EXP]      = exp_hi; // RULE14
    // remote masters always use the protected-mode window
    cmp_addr[lmd_pkg::LMD_RG_RDP]    = r.rem_s2[23:0];
    cmp_lo[lmd_pkg::LMD_RG_RDP]      = `LMD_DP_LO_PV; // RULE1
    cmp_hi[lmd_pkg::LMD_RG_RDP]      = `LMD_DP_LO_PV + dp_span - 24'h000001;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_cmp
      lmd_range_match u_match (
        .addr_in (cmp_addr[gi]),
        .lo_in   (cmp_lo[gi]),
        .hi_in   (cmp_hi[gi]),
        .hit_out (hit[gi])
      );
    end
  endgenerate

  // ========================================================
  // region choice and wait count
  logic [4:0] pick;
  logic [1:0] waits;
  logic       local_hit;
  logic       accept;
  logic       wait_last;

  // jumper code 0..3 maps to 1,2,3,3 wait states
  function automatic logic [1:0] lmd_local_waits(input logic [1:0] code);
    lmd_local_waits = (code == `LMD_LOC_WAIT_MAX) ? `LMD_LOC_WAIT_MAX
                                                   : code + 2'h1;
  endfunction : lmd_local_waits

  always_comb begin
    pick  = 5'h00;
    waits = SYS_WAITS;
    // dual-port wins where a local window overlaps it
    if (hit[lmd_pkg::LMD_RG_DP]) begin
      pick[2] = 1'b1; // RULE18
      waits   = `LMD_DP_WAITS; // RULE4
    end else if (hit[lmd_pkg::LMD_RG_BOOT]) begin
      pick[0] = 1'b1;
      waits   = lmd_local_waits(bwt); // RULE5
    end else if (hit[lmd_pkg::LMD_RG_SECOND]) begin
      pick[1] = 1'b1;
      waits   = lmd_local_waits(swt); // RULE5
    end else if (hit[lmd_pkg::LMD_RG_EXP]) begin
      pick[3] = 1'b1;
      waits   = EXP_WAITS;
    end else begin
      pick[4] = 1'b1;
    end
    if (waits == 2'h0) begin
      waits = 2'h1;
    end
  end

  assign local_hit = pick[0] | pick[1];
  assign accept    = cpu_strobe_in & ~r.active;

  lmd_wait_count u_wait (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .start_in   (accept),
    .count_in   (waits),
    .last_out   (wait_last)
  );

  // ========================================================
  // next state
  always_comb begin
    n         = r;
    n.cfg_s1  = {dp_block_sel_in, second_wait_sel_in, boot_wait_sel_in,
                 secondary_opt_in, primary_opt_in};
    n.cfg_s2  = r.cfg_s1;
    n.cfg_s3  = r.cfg_s2;
    // strap word taken only once two synchronised samples agree
    if (r.cfg_s2 == r.cfg_s3) begin
      n.cfg_use = r.cfg_s3;
    end
    n.rem_s1  = {remote_valid_in, remote_addr_in};
    n.rem_s2  = r.rem_s1;
    // remote address used only after valid stood two cycles, so its bits settled
    n.rem_ok  = r.rem_s2[24];
    n.rsel    = r.rem_s2[24] & r.rem_ok & hit[lmd_pkg::LMD_RG_RDP]; // RULE1
    n.refused = 1'b0;
    n.ready   = r.active & wait_last & ~r.ready;
    if (r.ready) begin
      n.active = 1'b0;
      n.sel    = 5'h00;
    end
    if (accept) begin
      n.active = 1'b1;
      if (cpu_write_in && local_hit) begin
        // EPROM pairs take no writes; cycle still completes
        n.sel     = 5'h00; // RULE16
        n.refused = 1'b1;
      end else begin
        n.sel = pick; // RULE18
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ========================================================
  // outputs
  assign boot_sel_out             = r.sel[0];
  assign second_sel_out           = r.sel[1];
  assign dual_port_sel_out        = r.sel[2];
  assign expansion_sel_out        = r.sel[3];
  assign system_bus_sel_out       = r.sel[4];
  assign cpu_ready_out            = r.ready;
  assign write_refused_out        = r.refused;
  assign remote_dual_port_sel_out = r.rsel;

endmodule : lmd_decoder
`default_nettype wire

// *** logic/lmd_cfg.svh ***
// lmd_cfg.svh: address map, field positions and wait figures of the
// local memory decoder.
// assumes: 24-bit byte addresses; real-mode figures stored zero-extended.
`ifndef LMD_CFG_SVH
`define LMD_CFG_SVH

// ==========================================================
// fixed map points
`define LMD_TOP_PV       24'hffffff
`define LMD_TOP_RM       24'h0fffff
`define LMD_RM_MASK      24'h0fffff
`define LMD_DP_LO_PV     24'hfec000
`define LMD_DP_LO_RM     24'h0ec000
`define LMD_DP_SPAN_LG   24'h004000
`define LMD_DP_SPAN_SM   24'h002000
`define LMD_EXP_LO       24'h000000
`define LMD_BLK_LSB      14

// ==========================================================
// primary decode tables: boot low end, second window, expansion top
`define LMD_O0_BOOT_PV   24'hffc000
`define LMD_O0_BOOT_RM   24'h0fc000
`define LMD_O0_SLO_PV    24'hff0000
`define LMD_O0_SHI_PV    24'hffbfff
`define LMD_O0_SLO_RM    24'h0f0000
`define LMD_O0_SHI_RM    24'h0fbfff
`define LMD_O0_EHI_RM    24'h0dffff
`define LMD_O1_BOOT_PV   24'hff8000
`define LMD_O1_BOOT_RM   24'h0f8000
`define LMD_O1_SLO_PV    24'hff0000
`define LMD_O1_SHI_PV    24'hff7fff
`define LMD_O1_SLO_RM    24'h0f0000
`define LMD_O1_SHI_RM    24'h0f7fff
`define LMD_O1_EHI_RM    24'h0dffff
`define LMD_O2_BOOT_PV   24'hff0000
`define LMD_O2_BOOT_RM   24'h0f0000
`define LMD_O2_SLO_PV    24'hfc0000
`define LMD_O2_SHI_PV    24'hfeffff
`define LMD_O2_SLO_RM    24'h0c0000
`define LMD_O2_SHI_RM    24'h0effff
`define LMD_O2_EHI_RM    24'h09ffff
`define LMD_O3_BOOT_PV   24'hfe0000
`define LMD_O3_BOOT_RM   24'h0f0000
`define LMD_O3_SLO_PV    24'hfc0000
`define LMD_O3_SHI_PV    24'hfdffff
`define LMD_O3_SLO_RM    24'h0c0000
`define LMD_O3_SHI_RM    24'h0effff
`define LMD_O3_EHI_RM    24'h09ffff
`define LMD_EHI_PV       24'hdfffff

// ==========================================================
// packed strap word and wait figures
`define LMD_CF_W         10
`define LMD_CF_PRI_LSB   0
`define LMD_CF_SEC_LSB   2
`define LMD_CF_BWT_LSB   5
`define LMD_CF_SWT_LSB   7
`define LMD_CF_DPB_BIT   9
`define LMD_DP_WAITS     2'h2
`define LMD_LOC_WAIT_MAX 2'h3

`endif

// *** logic/lmd_pkg.sv ***
// lmd_pkg: types of the local memory decoder.
// assumes: lmd_cfg.svh is on the include path.
`include "lmd_cfg.svh"
package lmd_pkg;

  // ========================================================
  // region index
  typedef enum logic [2:0] {
    LMD_RG_BOOT   = 3'h0,
    LMD_RG_SECOND = 3'h1,
    LMD_RG_DP     = 3'h2,
    LMD_RG_EXP    = 3'h3,
    LMD_RG_RDP    = 3'h4
  } lmd_region_t;

  typedef struct packed {
    logic [1:0] cnt;
  } lmd_wait_state_t;

  typedef struct packed {
    logic [`LMD_CF_W-1:0] cfg_s1;
    logic [`LMD_CF_W-1:0] cfg_s2;
    logic [`LMD_CF_W-1:0] cfg_s3;
    logic [`LMD_CF_W-1:0] cfg_use;
    logic [24:0]          rem_s1;
    logic [24:0]          rem_s2;
    logic                 rem_ok;
    logic [4:0]           sel;
    logic                 active;
    logic                 ready;
    logic                 refused;
    logic                 rsel;
  } lmd_state_t;

endpackage : lmd_pkg

// *** logic/lmd_range_match.sv ***
// lmd_range_match: inclusive address window compare.
// assumes: lo_in not above hi_in.
`timescale 1ns/1ns
`default_nettype none
module lmd_range_match (
  input  wire logic [23:0] addr_in,
  input  wire logic [23:0] lo_in,
  input  wire logic [23:0] hi_in,
  output logic             hit_out
);
  assign hit_out = (addr_in >= lo_in) && (addr_in <= hi_in);
endmodule : lmd_range_match
`default_nettype wire

// *** logic/lmd_wait_count.sv ***
// lmd_wait_count: down counter for access wait states.
// assumes: start_in only while idle; count_in at least one.
`timescale 1ns/1ns
`default_nettype none
module lmd_wait_count (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       start_in,
  input  wire logic [1:0] count_in,
  output logic            last_out
);
  lmd_pkg::lmd_wait_state_t r, n;

  always_comb begin
    n = r;
    if (start_in) begin
      n.cnt = count_in;
    end else if (r.cnt != 2'h0) begin
      n.cnt = r.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // high in the final wait cycle
  assign last_out = (r.cnt == 2'h1);
endmodule : lmd_wait_count
`default_nettype wire

// *** tb/lmd_remote_master.sv ***
// lmd_remote_master: remote bus master reaching the dual-port window.
// assumes: driven by the bench just after the decoder clock edge.
`timescale 1ns/1ns
`default_nettype none
module lmd_remote_master (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [23:0] addr_in,
  output logic             valid_out,
  output logic [23:0]      addr_out
);
  initial begin
    valid_out = 1'b0;
    addr_out  = 24'h000000;
  end
  // idle address keeps toggling so a stale value never looks like a request
  always @(posedge clk_in) begin
    valid_out <= go_in;
    addr_out  <= go_in ? addr_in : ~addr_out;
  end
endmodule : lmd_remote_master
`default_nettype wire

// *** tb/lmd_decoder_monitor.sv ***
// lmd_decoder_monitor: port-level checks of the local memory decoder.
// assumes: bound to lmd_decoder; one clock, synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module lmd_decoder_monitor (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        cpu_strobe_in,
  input wire logic        cpu_write_in,
  input wire logic [23:0] cpu_addr_in,
  input wire logic        protected_virtual_mode_in,
  input wire logic        remote_valid_in,
  input wire logic [23:0] remote_addr_in,
  input wire logic        boot_sel_out,
  input wire logic        second_sel_out,
  input wire logic        dual_port_sel_out,
  input wire logic        expansion_sel_out,
  input wire logic        system_bus_sel_out,
  input wire logic        cpu_ready_out,
  input wire logic        write_refused_out,
  input wire logic        remote_dual_port_sel_out
);
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [4:0] sel_w;
  assign sel_w = {boot_sel_out, second_sel_out, dual_port_sel_out, expansion_sel_out,
                  system_bus_sel_out};

  property p_one_sel; $onehot0(sel_w); endproperty
  a_one_sel: assert property (p_one_sel) else $error("several region selects");
  property p_sel_cause; $rose(|sel_w) |-> $past(cpu_strobe_in); endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select without strobe");
  property p_dp_wait;
    $rose(dual_port_sel_out) |-> !cpu_ready_out ##1 (dual_port_sel_out && !cpu_ready_out)
      ##1 (dual_port_sel_out && cpu_ready_out) ##1 !dual_port_sel_out;
  endproperty
  a_dp_wait: assert property (p_dp_wait) else $error("dual-port wait count");
  property p_boot_wait; $rose(boot_sel_out) |-> ##[1:3] cpu_ready_out; endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("boot wait count");
  property p_ready_pulse; cpu_ready_out |=> !cpu_ready_out && sel_w == 5'h00; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not ending access");
  property p_refused;
    write_refused_out |-> !boot_sel_out && !second_sel_out && $past(cpu_strobe_in)
      && $past(cpu_write_in);
  endproperty
  a_refused: assert property (p_refused) else $error("bad write refusal");
  property p_boot_top;
    $rose(boot_sel_out) |-> ($past(protected_virtual_mode_in) ?
      $past(cpu_addr_in[23:17]) == 7'h7f : $past(cpu_addr_in[19:16]) == 4'hf);
  endproperty
  a_boot_top: assert property (p_boot_top) else $error("boot select off top");
  property p_dp_place;
    $rose(dual_port_sel_out) |-> ($past(protected_virtual_mode_in) ?
      $past(cpu_addr_in[23:14]) == 10'h3fb : $past(cpu_addr_in[19:14]) == 6'h3b);
  endproperty
  a_dp_place: assert property (p_dp_place) else $error("dual-port window");
  property p_remote;
    remote_dual_port_sel_out |-> $past(remote_valid_in, 4) && $past(remote_valid_in, 3)
      && $past(remote_addr_in[23:14], 3) == 10'h3fb;
  endproperty
  a_remote: assert property (p_remote) else $error("remote select window");
  c_dp: cover property ($rose(dual_port_sel_out));
  c_refused: cover property (write_refused_out);
  c_remote: cover property ($rose(remote_dual_port_sel_out));
endmodule : lmd_decoder_monitor

bind lmd_decoder lmd_decoder_monitor u_lmd_decoder_monitor (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .cpu_strobe_in(cpu_strobe_in),
  .cpu_write_in(cpu_write_in), .cpu_addr_in(cpu_addr_in),
  .protected_virtual_mode_in(protected_virtual_mode_in), .remote_valid_in(remote_valid_in),
  .remote_addr_in(remote_addr_in), .boot_sel_out(boot_sel_out),
  .second_sel_out(second_sel_out), .dual_port_sel_out(dual_port_sel_out),
  .expansion_sel_out(expansion_sel_out), .system_bus_sel_out(system_bus_sel_out),
  .cpu_ready_out(cpu_ready_out), .write_refused_out(write_refused_out),
  .remote_dual_port_sel_out(remote_dual_port_sel_out));
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: directed accesses through the decoder's strobe/ready protocol.
// assumes: lmd_decoder with default parameters, remote master model alongside.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_in, reset_n_in, cpu_strobe_in, cpu_write_in, pvm, dpb;
  logic [23:0] cpu_addr_in, raddr, remote_addr;
  logic [1:0]  pri, bw, sw;
  logic [2:0]  sec;
  logic        rgo, remote_valid, ready, refused, rsel;
  logic [4:0]  sel;
  int          bad_count, checked;
  localparam logic [4:0] BT = 5'h10, SC = 5'h08, DP = 5'h04, EX = 5'h02, SY = 5'h01;

  lmd_decoder u_lmd_decoder (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .cpu_strobe_in(cpu_strobe_in),
    .cpu_write_in(cpu_write_in), .cpu_addr_in(cpu_addr_in),
    .protected_virtual_mode_in(pvm), .primary_opt_in(pri), .secondary_opt_in(sec),
    .boot_wait_sel_in(bw), .second_wait_sel_in(sw), .dp_block_sel_in(dpb),
    .remote_valid_in(remote_valid), .remote_addr_in(remote_addr),
    .boot_sel_out(sel[4]), .second_sel_out(sel[3]), .dual_port_sel_out(sel[2]),
    .expansion_sel_out(sel[1]), .system_bus_sel_out(sel[0]), .cpu_ready_out(ready),
    .write_refused_out(refused), .remote_dual_port_sel_out(rsel));
  lmd_remote_master u_lmd_remote_master (
    .clk_in(clk_in), .go_in(rgo), .addr_in(raddr), .valid_out(remote_valid),
    .addr_out(remote_addr));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [23:0] a, input logic [4:0] es,
                     input int ew, input logic er);
    int         n;
    logic [4:0] s;
    logic       r;
    @(posedge clk_in);
    #1;
    cpu_strobe_in = 1'b1;
    cpu_write_in  = w;
    cpu_addr_in   = a;
    @(posedge clk_in);
    #1;
    cpu_strobe_in = 1'b0;
    cpu_write_in  = 1'b0;
    s = sel;
    r = refused;
    n = 1;
    while (ready !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({27'h0, s}, {27'h0, es});
    chk({31'h0, r}, {31'h0, er});
    chk(n, ew + 1);
  endtask : acc

  task automatic cfg(input logic [1:0] p, input logic [2:0] s, input logic [1:0] b,
                     input logic [1:0] c, input logic d, input logic m);
    @(posedge clk_in);
    #1;
    pri = p;
    sec = s;
    bw  = b;
    sw  = c;
    dpb = d;
    pvm = m;
    repeat (3) @(posedge clk_in);
  endtask : cfg

  task automatic rem(input logic [23:0] a, input logic e);
    @(posedge clk_in);
    #1;
    rgo   = 1'b1;
    raddr = a;
    repeat (5) @(posedge clk_in);
    #1;
    chk({31'h0, rsel}, {31'h0, e});
    rgo = 1'b0;
    repeat (5) @(posedge clk_in);
  endtask : rem

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // stimulus
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    #600000;
    bad_count++;
    conclude();
  end

  initial begin
    {reset_n_in, cpu_strobe_in, cpu_write_in, cpu_addr_in, rgo, raddr} = '0;
    {pri, sec, bw, sw, dpb, pvm} = {2'h1, 3'h0, 2'h0, 2'h0, 1'b1, 1'b1};
    bad_count = 0;
    checked = 0;
    repeat (4) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    acc(1'b0, 24'hffffff, BT, 1, 1'b0);
    acc(1'b0, 24'hff7fff, SC, 1, 1'b0);
    acc(1'b0, 24'hff0000, SC, 1, 1'b0);
    acc(1'b0, 24'hfec000, DP, 2, 1'b0);
    acc(1'b0, 24'hfeffff, DP, 2, 1'b0);
    acc(1'b0, 24'hdfffff, EX, 1, 1'b0);
    acc(1'b0, 24'he00000, SY, 1, 1'b0);
    acc(1'b1, 24'hff8000, 5'h00, 1, 1'b1);
    acc(1'b1, 24'hfec000, DP, 2, 1'b0);
    rem(24'hfec000, 1'b1);
    rem(24'h0ec000, 1'b0);
    cfg(2'h1, 3'h0, 2'h2, 2'h1, 1'b1, 1'b0);
    acc(1'b0, 24'h0ec000, DP, 2, 1'b0);
    acc(1'b0, 24'hff8000, BT, 3, 1'b0);
    acc(1'b0, 24'h0f0000, SC, 2, 1'b0);
    acc(1'b0, 24'h0e0000, SY, 1, 1'b0);
    rem(24'hfec000, 1'b1);
    cfg(2'h1, 3'h0, 2'h3, 2'h0, 1'b0, 1'b1);
    acc(1'b0, 24'hfedfff, DP, 2, 1'b0);
    acc(1'b0, 24'hfee000, SY, 1, 1'b0);
    acc(1'b0, 24'hff8000, BT, 3, 1'b0);
    cfg(2'h0, 3'h0, 2'h0, 2'h0, 1'b1, 1'b1);
    acc(1'b0, 24'hffc000, BT, 1, 1'b0);
    acc(1'b0, 24'hffbfff, SC, 1, 1'b0);
    cfg(2'h2, 3'h1, 2'h0, 2'h0, 1'b1, 1'b1);
    acc(1'b0, 24'hff0000, BT, 1, 1'b0);
    acc(1'b0, 24'hfe8000, SC, 1, 1'b0);
    acc(1'b0, 24'hfd0000, SY, 1, 1'b0);
    cfg(2'h2, 3'h5, 2'h0, 2'h0, 1'b1, 1'b1);
    acc(1'b0, 24'hfd0000, SC, 1, 1'b0);
    cfg(2'h2, 3'h0, 2'h0, 2'h0, 1'b1, 1'b0);
    acc(1'b0, 24'h0a0000, SY, 1, 1'b0);
    acc(1'b0, 24'h09ffff, EX, 1, 1'b0);
    cfg(2'h3, 3'h0, 2'h0, 2'h0, 1'b1, 1'b1);
    acc(1'b0, 24'hfe0000, BT, 1, 1'b0);
    acc(1'b0, 24'hfdffff, SC, 1, 1'b0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
